// ---- src/scb_defines.vh ----
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH

// =====================================
// register offsets (byte addresses)
`define SCB_ADDR_W          12
`define SCB_OFS_IRC         12'hD0C
`define SCB_OFS_SLEEP       12'hD10
`define SCB_OFS_PRI_SVC     12'hD1C
`define SCB_OFS_PRI_TP      12'hD20

// =====================================
// reset values
`define SCB_RST_IRC         32'h00000000
`define SCB_RST_SLEEP       32'h00000000
`define SCB_RST_PRI_SVC     32'h00000000
`define SCB_RST_PRI_TP      32'h00000000

// =====================================
// interrupt and reset control fields
`define SCB_KEY_HI          31
`define SCB_KEY_LO          16
`define SCB_KEY_VALUE       16'h05FA
`define SCB_BYTE_ORDER_BIT  15
`define SCB_RESET_REQ_BIT   2
`define SCB_CLR_ACTIVE_BIT  1

// =====================================
// sleep control fields
`define SCB_WAKE_PEND_BIT   4
`define SCB_DEEP_SLEEP_BIT  2
`define SCB_SLEEP_EXIT_BIT  1

// =====================================
// priority fields
`define SCB_PRI_SVC_HI      31
`define SCB_PRI_SVC_LO      30
`define SCB_PRI_TICK_HI     31
`define SCB_PRI_TICK_LO     30
`define SCB_PRI_PEND_HI     23
`define SCB_PRI_PEND_LO     22

// =====================================
// interrupt lines watched for wake-up
`define SCB_NUM_IRQ         32

`endif

// ---- src/scb_wake_event.v ----
`include "scb_defines.vh"

// =====================================
// event latch for wait-for-event
module scb_wake_event
(
	input  wire                      clk,
	input  wire                      rst,
	input  wire                      wake_on_pending,
	input  wire [`SCB_NUM_IRQ-1:0]   irq_pending,
	input  wire [`SCB_NUM_IRQ-1:0]   irq_enabled,
	input  wire                      ext_event,
	input  wire                      send_event,
	input  wire                      wfe_waiting,
	input  wire                      wfe_consume,
	output reg                       event_latched,
	output reg                       wake
);

	reg  [`SCB_NUM_IRQ-1:0] prev_pending;
	wire [`SCB_NUM_IRQ-1:0] rising;
	wire                    irq_event;
	wire                    any_event;
	wire                    wake_level;

	assign rising     = irq_pending & ~prev_pending;
	// disabled lines only count as events with wake-on-pending
	assign irq_event  = wake_on_pending ? (|rising) : (|(rising & irq_enabled));
	assign any_event  = irq_event | ext_event | send_event;
	// wake level: all pending lines or only enabled ones
	assign wake_level = wake_on_pending ? (|irq_pending) : (|(irq_pending & irq_enabled));

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_pending  <= {`SCB_NUM_IRQ{1'b0}};
			event_latched <= 1'b0;
			wake          <= 1'b0;
		end
		else
		begin
			prev_pending <= irq_pending;
			// a new event while not waiting wins over the consume in the same cycle
			if (any_event && !wfe_waiting)
				event_latched <= 1'b1;
			else if (wfe_consume)
				event_latched <= 1'b0;
			wake <= wake_level | any_event | (wfe_waiting & event_latched);
		end
	end

endmodule

// ---- src/scb_regs.v ----
`include "scb_defines.vh"

// =====================================
// Function
// - the byte order bit 15 of the control word always reads zero for little endian.
// - writing one to bit 2 with key 05FA in bits 31..16 raises the system reset request output.
// - writing one to bit 1 with key 05FA while debug halted pulses a clear of all active exception state.
// - wake-on-pending clear wakes on enabled lines only, set wakes on every line.
// - with wake-on-pending set, any line going pending counts as a wait-for-event wake.
// - an event seen while not waiting is latched so the next wait returns at once.
// - a send-event instruction wakes or pre-arms the wait-for-event.
// - the deep sleep select bit picks ordinary sleep (0) or deep sleep (1).
// - the deep sleep select bit is driven out to the power control logic.
// - the sleep-on-exit bit makes the core sleep on return to thread mode.
// - bits 31..30 of the svc priority register hold the supervisor-call priority.
// - bits 31..30 of the tick/pend register hold the system-tick priority.
// - bits 23..22 of the tick/pend register hold the pendable-service priority.
module scb_regs
(
	input  wire                      clk,
	input  wire                      rst,
	input  wire [`SCB_ADDR_W-1:0]    addr,
	input  wire [31:0]               wdata,
	input  wire                      wr,
	input  wire                      rd,
	output reg  [31:0]               rdata,
	input  wire                      debug_halted,
	input  wire [`SCB_NUM_IRQ-1:0]   irq_pending,
	input  wire [`SCB_NUM_IRQ-1:0]   irq_enabled,
	input  wire                      ext_event,
	input  wire                      send_event,
	input  wire                      wfe_waiting,
	input  wire                      wfe_consume,
	output reg                       system_reset_request,
	output reg                       clear_active_exceptions,
	output reg                       deep_sleep_select,
	output reg                       sleep_on_exit,
	output reg                       wake_on_pending,
	output reg  [1:0]                supervisor_call_priority,
	output reg  [1:0]                system_tick_priority,
	output reg  [1:0]                pendable_service_priority,
	output reg                       wfe_event_latched,
	output reg                       wfe_wake
);

	// =====================================
	// synchronised pin inputs
	reg  [`SCB_NUM_IRQ-1:0] pend_s1;
	reg  [`SCB_NUM_IRQ-1:0] pend_s2;
	reg  [`SCB_NUM_IRQ-1:0] en_s1;
	reg  [`SCB_NUM_IRQ-1:0] en_s2;
	reg                     evt_s1;
	reg                     evt_s2;
	reg                     halt_s1;
	reg                     halt_s2;

	wire                    event_latched;
	wire                    wake;
	wire                    key_ok;
	wire                    wr_irc;
	wire                    wr_sleep;
	wire                    wr_svc;
	wire                    wr_tp;
	reg  [31:0]             next_rdata;

	function hit;
		input [`SCB_ADDR_W-1:0] a;
		input [`SCB_ADDR_W-1:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// external pins are async to clk
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pend_s1 <= {`SCB_NUM_IRQ{1'b0}};
			pend_s2 <= {`SCB_NUM_IRQ{1'b0}};
			en_s1   <= {`SCB_NUM_IRQ{1'b0}};
			en_s2   <= {`SCB_NUM_IRQ{1'b0}};
			evt_s1  <= 1'b0;
			evt_s2  <= 1'b0;
			halt_s1 <= 1'b0;
			halt_s2 <= 1'b0;
		end
		else
		begin
			pend_s1 <= irq_pending;
			pend_s2 <= pend_s1;
			en_s1   <= irq_enabled;
			en_s2   <= en_s1;
			evt_s1  <= ext_event;
			evt_s2  <= evt_s1;
			halt_s1 <= debug_halted;
			halt_s2 <= halt_s1;
		end
	end

	// =====================================
	// write decode
	assign key_ok   = (wdata[`SCB_KEY_HI:`SCB_KEY_LO] == `SCB_KEY_VALUE);
	assign wr_irc   = wr & hit(addr, `SCB_OFS_IRC) & key_ok;
	assign wr_sleep = wr & hit(addr, `SCB_OFS_SLEEP);
	assign wr_svc   = wr & hit(addr, `SCB_OFS_PRI_SVC);
	assign wr_tp    = wr & hit(addr, `SCB_OFS_PRI_TP);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			system_reset_request      <= 1'b0;
			clear_active_exceptions   <= 1'b0;
			deep_sleep_select         <= 1'b0;
			sleep_on_exit             <= 1'b0;
			wake_on_pending           <= 1'b0;
			supervisor_call_priority  <= 2'h0;
			system_tick_priority      <= 2'h0;
			pendable_service_priority <= 2'h0;
		end
		else
		begin
			// sticky: only the reset it causes clears it
			if (wr_irc && wdata[`SCB_RESET_REQ_BIT])
				system_reset_request <= 1'b1;
			// undefined outside debug halt, so only honoured while halted
			clear_active_exceptions <= wr_irc & wdata[`SCB_CLR_ACTIVE_BIT] & halt_s2;
			if (wr_sleep)
			begin
				deep_sleep_select <= wdata[`SCB_DEEP_SLEEP_BIT];
				sleep_on_exit     <= wdata[`SCB_SLEEP_EXIT_BIT];
				wake_on_pending   <= wdata[`SCB_WAKE_PEND_BIT];
			end
			if (wr_svc)
				supervisor_call_priority <= wdata[`SCB_PRI_SVC_HI:`SCB_PRI_SVC_LO];
			if (wr_tp)
			begin
				system_tick_priority      <= wdata[`SCB_PRI_TICK_HI:`SCB_PRI_TICK_LO];
				pendable_service_priority <= wdata[`SCB_PRI_PEND_HI:`SCB_PRI_PEND_LO];
			end
		end
	end

	// =====================================
	// read mux, reserved bits zero
	always @*
	begin
		next_rdata = 32'h00000000;
		if (rd)
		begin
			case (addr)
				`SCB_OFS_IRC:
				begin
					// byte order bit left at zero: little endian
					next_rdata[`SCB_BYTE_ORDER_BIT] = 1'b0;
					next_rdata[`SCB_RESET_REQ_BIT]  = system_reset_request;
				end
				`SCB_OFS_SLEEP:
				begin
					next_rdata[`SCB_WAKE_PEND_BIT]  = wake_on_pending;
					next_rdata[`SCB_DEEP_SLEEP_BIT] = deep_sleep_select;
					next_rdata[`SCB_SLEEP_EXIT_BIT] = sleep_on_exit;
				end
				`SCB_OFS_PRI_SVC:
					next_rdata[`SCB_PRI_SVC_HI:`SCB_PRI_SVC_LO] = supervisor_call_priority;
				`SCB_OFS_PRI_TP:
				begin
					next_rdata[`SCB_PRI_TICK_HI:`SCB_PRI_TICK_LO] = system_tick_priority;
					next_rdata[`SCB_PRI_PEND_HI:`SCB_PRI_PEND_LO] = pendable_service_priority;
				end
				default:
					next_rdata = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 32'h00000000;
		else
			rdata <= next_rdata;
	end

	// =====================================
	// wait-for-event logic
	scb_wake_event u_wake
	(
		.clk             (clk),
		.rst             (rst),
		.wake_on_pending (wake_on_pending),
		.irq_pending     (pend_s2),
		.irq_enabled     (en_s2),
		.ext_event       (evt_s2),
		.send_event      (send_event),
		.wfe_waiting     (wfe_waiting),
		.wfe_consume     (wfe_consume),
		.event_latched   (event_latched),
		.wake            (wake)
	);

	// outputs registered; costs one cycle of wake latency
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wfe_event_latched <= 1'b0;
			wfe_wake          <= 1'b0;
		end
		else
		begin
			wfe_event_latched <= event_latched;
			wfe_wake          <= wake;
		end
	end

endmodule

// ---- bench/scb_regs_properties.sv ----
`include "scb_defines.vh"
// ====
// port checks
module scb_regs_properties
(
	input wire        clk,
	input wire        rst,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire        send_event,
	input wire        wfe_consume,
	input wire        system_reset_request,
	input wire        clear_active_exceptions,
	input wire        deep_sleep_select,
	input wire        sleep_on_exit,
	input wire        wake_on_pending,
	input wire [1:0]  supervisor_call_priority,
	input wire [1:0]  system_tick_priority,
	input wire [1:0]  pendable_service_priority,
	input wire        wfe_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire w_sl = wr && addr == `SCB_OFS_SLEEP;
	wire w_svc = wr && addr == `SCB_OFS_PRI_SVC;
	wire w_tp = wr && addr == `SCB_OFS_PRI_TP;
	wire w_ctl = wr && addr == `SCB_OFS_IRC;
	wire w_key = w_ctl && wdata[31:16] == `SCB_KEY_VALUE;
	a_deep_sleep: assert property (w_sl |=> deep_sleep_select == $past(wdata[2]))
		else $error("deep sleep select wrong");
	a_sleep_exit: assert property (w_sl |=> sleep_on_exit == $past(wdata[1]))
		else $error("sleep on exit wrong");
	a_wake_pend: assert property (w_sl |=> wake_on_pending == $past(wdata[4]))
		else $error("wake on pending wrong");
	a_svc_pri: assert property (w_svc |=> supervisor_call_priority == $past(wdata[31:30]))
		else $error("svc priority wrong");
	a_tick_pri: assert property (w_tp |=> system_tick_priority == $past(wdata[31:30]))
		else $error("tick priority wrong");
	a_pend_pri: assert property (w_tp |=> pendable_service_priority == $past(wdata[23:22]))
		else $error("pend priority wrong");
	a_bad_key: assert property (w_ctl && !w_key |=> $stable(system_reset_request))
		else $error("keyless write took effect");
	a_reset_set: assert property (w_key && wdata[2] |=> system_reset_request)
		else $error("reset request not raised");
	a_reset_hold: assert property (system_reset_request |=> system_reset_request)
		else $error("reset request dropped");
	a_order_zero: assert property (rd && addr == `SCB_OFS_IRC |=> !rdata[15])
		else $error("byte order bit set");
	a_clear_cause: assert property (clear_active_exceptions |-> $past(w_key && wdata[1]))
		else $error("clear pulse without write");
	a_sev_wake: assert property (send_event && !wfe_consume ##1 !wfe_consume |=> wfe_wake)
		else $error("send event gave no wake");
	c_key_write: cover property (w_key);
	c_clear: cover property (clear_active_exceptions);
	c_wake: cover property (wfe_wake);
endmodule
bind scb_regs scb_regs_properties scb_regs_properties_i (.clk, .rst, .addr, .wdata, .wr, .rd,
	.rdata, .send_event, .wfe_consume, .system_reset_request, .clear_active_exceptions,
	.deep_sleep_select, .sleep_on_exit, .wake_on_pending, .supervisor_call_priority,
	.system_tick_priority, .pendable_service_priority, .wfe_wake);

// ---- bench/scb_core_model.sv ----
`include "scb_defines.vh"
// ====
// core side
module scb_core_model
(
	input  wire                     clk,
	output logic                    debug_halted,
	output logic [`SCB_NUM_IRQ-1:0] irq_pending,
	output logic [`SCB_NUM_IRQ-1:0] irq_enabled,
	output logic                    ext_event,
	output logic                    send_event,
	output logic                    wfe_waiting,
	output logic                    wfe_consume
);
	timeunit 1ns;
	timeprecision 1ps;
	// starts not waiting, so events are latched until set_wait raises wfe_waiting
	initial
	begin
		{debug_halted, ext_event, send_event, wfe_waiting, wfe_consume} = 5'h0;
		irq_pending = 32'h0;
		irq_enabled = 32'h0;
	end
	task automatic pulse_sev();
		@(posedge clk);
		send_event <= 1'b1;
		@(posedge clk);
		send_event <= 1'b0;
	endtask
	task automatic pulse_consume();
		@(posedge clk);
		wfe_consume <= 1'b1;
		@(posedge clk);
		wfe_consume <= 1'b0;
	endtask
	task automatic set_lines(input logic [31:0] p, input logic [31:0] e);
		@(posedge clk);
		irq_pending <= p;
		irq_enabled <= e;
	endtask
	// pin is synchronised, so hold it two cycles
	task automatic pulse_ext();
		@(posedge clk);
		ext_event <= 1'b1;
		repeat (2) @(posedge clk);
		ext_event <= 1'b0;
	endtask
	task automatic set_wait(input logic w);
		@(posedge clk);
		wfe_waiting <= w;
	endtask
	task automatic set_halt(input logic h);
		@(posedge clk);
		debug_halted <= h;
	endtask
endmodule

// ---- bench/scb_regs_bench.sv ----
`include "scb_defines.vh"
module scb_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd;
	logic [11:0] addr;
	logic [31:0] wdata;
	wire [31:0] rdata, irq_pending, irq_enabled;
	wire debug_halted, ext_event, send_event, wfe_waiting, wfe_consume;
	wire system_reset_request, clear_active_exceptions, deep_sleep_select, sleep_on_exit;
	wire wake_on_pending, wfe_event_latched, wfe_wake;
	wire [1:0] supervisor_call_priority, system_tick_priority, pendable_service_priority;
	wire [8:0] fgot = {wake_on_pending, deep_sleep_select, sleep_on_exit, supervisor_call_priority,
		system_tick_priority, pendable_service_priority};
	logic [11:0] regs [5] = '{`SCB_OFS_IRC, `SCB_OFS_SLEEP, `SCB_OFS_PRI_SVC, `SCB_OFS_PRI_TP, 12'h000};
	logic [31:0] st [5] = '{default: 32'h0};
	int miscompares = 0;
	int checks_done = 0;
	int clr_pulses = 0;
	scb_core_model scb_core_model_i (.clk, .debug_halted, .irq_pending, .irq_enabled, .ext_event,
		.send_event, .wfe_waiting, .wfe_consume);
	scb_regs scb_regs_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .debug_halted, .irq_pending,
		.irq_enabled, .ext_event, .send_event, .wfe_waiting, .wfe_consume, .system_reset_request,
		.clear_active_exceptions, .deep_sleep_select, .sleep_on_exit, .wake_on_pending,
		.supervisor_call_priority, .system_tick_priority, .pendable_service_priority,
		.wfe_event_latched, .wfe_wake);
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
		if (clear_active_exceptions === 1'b1) clr_pulses++;
	// ====
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", exp, rdata);
	endtask
	function automatic logic [31:0] exp_of(input int i, input logic [31:0] d);
		case (i)
			1: return d & 32'h00000016;
			2: return d & 32'hC0000000;
			3: return d & 32'hC0C00000;
			default: return 32'h00000000;
		endcase
	endfunction
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
	// ====
	// scenarios
	initial
	begin
		int i;
		logic [31:0] d;
		{rst, wr, rd, addr, wdata} = {3'b100, 12'h000, 32'h0};
		void'($urandom(32'h24CE));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (regs[k]) rd_chk(regs[k], 32'h0);
		for (int n = 0; n < 24; n++)
		begin
			i = 1 + $urandom_range(3);
			d = (n < 4) ? 32'hFFFFFFFF : $urandom;
			wr_reg(regs[i], d);
			st[i] = exp_of(i, d);
			rd_chk(regs[i], st[i]);
			d = {st[1][4], st[1][2], st[1][1], st[2][31:30], st[3][31:30], st[3][23:22]};
			chk("fields", d, fgot);
		end
		wr_reg(`SCB_OFS_IRC, 32'h05FB8006);
		rd_chk(`SCB_OFS_IRC, 32'h0);
		wr_reg(`SCB_OFS_IRC, 32'h05FA0002);
		scb_core_model_i.set_halt(1'b1);
		repeat (3) @(posedge clk);
		wr_reg(`SCB_OFS_IRC, 32'h05FA8002);
		repeat (3) @(posedge clk);
		chk("clear pulses", 1, clr_pulses);
		scb_core_model_i.pulse_sev();
		@(posedge clk);
		#1 chk("sev latch", 2'b11, {wfe_event_latched, wfe_wake});
		scb_core_model_i.pulse_consume();
		@(posedge clk);
		#1 chk("consumed", 0, wfe_event_latched);
		wr_reg(`SCB_OFS_SLEEP, 32'h0);
		scb_core_model_i.set_lines(32'h1, 32'h0);
		repeat (4) @(posedge clk);
		#1 chk("disabled line", 0, wfe_event_latched);
		wr_reg(`SCB_OFS_SLEEP, 32'h10);
		scb_core_model_i.set_lines(32'h3, 32'h0);
		repeat (4) @(posedge clk);
		#1 chk("pending wake", 1, wfe_event_latched);
		scb_core_model_i.pulse_consume();
		wr_reg(`SCB_OFS_SLEEP, 32'h0);
		scb_core_model_i.set_lines(32'h7, 32'h4);
		repeat (4) @(posedge clk);
		#1 chk("enabled line", 1, wfe_event_latched);
		scb_core_model_i.pulse_consume();
		scb_core_model_i.pulse_ext();
		#1 chk("ext pending", 0, wfe_event_latched);
		repeat (3) @(posedge clk);
		#1 chk("ext event", 1, wfe_event_latched);
		scb_core_model_i.pulse_consume();
		scb_core_model_i.set_lines(32'h0, 32'h0);
		scb_core_model_i.set_wait(1'b1);
		scb_core_model_i.pulse_sev();
		@(posedge clk);
		#1 chk("wait wake", 2'b01, {wfe_event_latched, wfe_wake});
		scb_core_model_i.set_wait(1'b0);
		wr_reg(`SCB_OFS_IRC, 32'h05FA0004);
		rd_chk(`SCB_OFS_IRC, 32'h00000004);
		repeat (3) @(posedge clk);
		chk("reset request", 1, system_reset_request);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk("reset request", 0, system_reset_request);
		rd_chk(`SCB_OFS_SLEEP, 32'h0);
		give_verdict();
	end
endmodule
